// >>> hw/rmc_pkg.sv
// package for the remote-terminal mode command handler
package rmc_pkg;

   // ****************************************************
   // command and response carriers
   // ****************************************************
   typedef struct packed {
      logic       broadcast;
      logic       tr_bit;
      logic [4:0] mode_code;
   } rmc_cmd_s;

   typedef struct packed {
      logic        ignored;
      logic        illegal;
      logic        send_status;
      logic        send_data;
      logic        rx_data;
      logic        msg_error;
      logic        dyn_bus_accept;
      logic [15:0] tx_data;
   } rmc_resp_s;

   typedef struct packed {
      logic [15:0] info_word;
      logic [15:0] addr_word;
   } rmc_log_s;

   // ****************************************************
   // layout constants
   // ****************************************************
   localparam int          RMC_IRQ_FIELD_HI  = 15;
   localparam int          RMC_IWA_BIT       = 15;
   localparam int          RMC_IIW_IWA_BIT   = 15;
   localparam logic [15:0] RMC_DESC_BASE_RST = 16'h0400;
   localparam logic [1:0]  RMC_DESC_STRIDE   = 2'h2;
   localparam logic        RMC_UMC_RST       = 1'b0;
   localparam logic        RMC_TABLE_RST     = 1'b0;
   localparam int          RMC_DATA_CODE_LO  = 16;
   localparam int          RMC_RESERVED_LO   = 9;

endpackage

// >>> hw/rmc_mode_handler.sv
// mode command decode, legality, response, mode data storage and interrupt log
//
// Behaviour
// - invalid option affects only the 22 undefined mode commands
// - option clear after reset; undefined commands then valid, legality from table
// - table bit 0 on valid command gives legal in-form response, status updated
// - table bit 1 sets message error; non-broadcast sends status only
// - option set: undefined commands ignored, no response, status unchanged
// - legalization table resets to all zero
// - all-zero table: codes 16-31 transmit give clear status plus stored data word
// - dynamic bus control never implemented; acceptance bit never set
// - descriptor control word top bit (bit 15) selects interrupt generation
// - broadcast transmit interrupts only for codes 0-15; 16-31 not allowed
// - access bit in descriptor and enable set pending bit and interrupt output
// - log info word with access bit and address word before interrupt output
// - logged address word is control word address by code and direction
// - codes 0-15 carry no data word; status only answer
// - codes 16-31 receive get exactly one data word after the command
// - legal codes 16-31 transmit send status then one data word
// - option clear: mode data in descriptor-named buffer, never circular
// - option set: mode data held inside the descriptor table
// - reserved codes 9-15 transmit carry no data and allow broadcast
// - undefined 17,20,21 transmit send data; 16,18,19 receive take data
`timescale 1ns/100ps
`default_nettype none

module rmc_mode_handler
   import rmc_pkg::*;
#(
   parameter int BUF_WORDS = 64
)
(
   input  wire logic           clk_sys,
   input  wire logic           reset_n,
   input  wire logic           undefined_codes_invalid_opt,
   input  wire logic           mode_data_in_table_opt,
   input  wire logic           irq_enable_iwa,
   input  wire logic           cmd_valid,
   input  wire rmc_pkg::rmc_cmd_s cmd,
   input  wire logic           data_valid,
   input  wire logic [15:0]    data_word,
   input  wire logic [15:0]    desc_ctrl_word,
   input  wire logic [5:0]     buf_index,
   input  wire logic           tbl_wr,
   input  wire logic [5:0]     tbl_addr,
   input  wire logic           tbl_bit,
   input  wire logic           pending_clear,
   input  wire logic           mem_wr,
   input  wire logic [5:0]     mem_addr,
   input  wire logic [15:0]    mem_wdata,
   output logic                resp_valid,
   output rmc_pkg::rmc_resp_s  resp,
   output logic                log_valid,
   output rmc_pkg::rmc_log_s   log_entry,
   output logic                pending_iwa,
   output logic                message_interrupt_out
);
   import rmc_pkg::*;

   // ****************************************************
   // decode helpers
   // ****************************************************
   function automatic logic is_undefined(input rmc_cmd_s c);
      logic u;
      u = 1'b0;
      if (!c.tr_bit && (c.mode_code < 5'd16))
         u = 1'b1;
      if (!c.tr_bit && (c.mode_code == 5'd16 || c.mode_code == 5'd18 ||
                        c.mode_code == 5'd19))
         u = 1'b1;
      if (c.tr_bit && (c.mode_code == 5'd17 || c.mode_code == 5'd20 ||
                       c.mode_code == 5'd21))
         u = 1'b1;
      return u;
   endfunction

   function automatic logic has_data(input rmc_cmd_s c);
      // codes 16..31 always carry one word, reserved 9..15 none
      return c.mode_code[4];
   endfunction

   function automatic logic [5:0] cmd_index(input rmc_cmd_s c);
      return {c.tr_bit, c.mode_code};
   endfunction

   // ****************************************************
   // legalization table and mode data stores
   // ****************************************************
   logic [63:0] legal_tbl_r;
   logic [63:0] legal_tbl_nxt;
   logic [15:0] buf_mem   [BUF_WORDS];
   logic [15:0] table_mem [32];

   always_comb
   begin
      legal_tbl_nxt = legal_tbl_r;
      if (tbl_wr)
         legal_tbl_nxt[tbl_addr] = tbl_bit;
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         legal_tbl_r <= {64{RMC_TABLE_RST}};
      else
         legal_tbl_r <= legal_tbl_nxt;
   end

   // ****************************************************
   // sequencer
   // ****************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_RXDATA, ST_LOG, ST_IRQ} rmc_state_e;

   rmc_state_e  state_r, state_nxt;
   rmc_cmd_s    cmd_r, cmd_nxt;
   logic [5:0]  bidx_r, bidx_nxt;
   logic        irq_req_r, irq_req_nxt;
   logic        resp_valid_r, resp_valid_nxt;
   rmc_resp_s   resp_r, resp_nxt;
   logic        log_valid_r, log_valid_nxt;
   rmc_log_s    log_r, log_nxt;
   logic        pend_r, pend_nxt;
   logic        irq_out_r, irq_out_nxt;
   logic        mem_we;
   logic [5:0]  mem_widx;
   logic        tbl_we;
   logic [4:0]  tbl_widx;
   logic [15:0] store_word;

   logic        undef_in, illegal_in, ign_in, irq_sel, store_en;
   logic [15:0] rd_word;

   always_comb
   begin
      undef_in   = is_undefined(cmd);
      ign_in     = undef_in && undefined_codes_invalid_opt;
      illegal_in = legal_tbl_r[cmd_index(cmd)];
      // broadcast transmit of 16..31 is not allowed: no interrupt selected
      irq_sel    = desc_ctrl_word[RMC_IWA_BIT] && irq_enable_iwa &&
                   !(cmd.broadcast && cmd.tr_bit && has_data(cmd));
      store_en   = 1'b0;
      rd_word    = mode_data_in_table_opt ? table_mem[cmd.mode_code]
                                          : buf_mem[buf_index];
      state_nxt      = state_r;
      cmd_nxt        = cmd_r;
      bidx_nxt       = bidx_r;
      irq_req_nxt    = irq_req_r;
      resp_valid_nxt = 1'b0;
      resp_nxt       = resp_r;
      log_valid_nxt  = 1'b0;
      log_nxt        = log_r;
      pend_nxt       = pend_r;
      irq_out_nxt    = irq_out_r;
      mem_we         = 1'b0;
      mem_widx       = bidx_r;
      tbl_we         = 1'b0;
      tbl_widx       = cmd_r.mode_code;
      store_word     = data_word;
      if (pending_clear)
      begin
         pend_nxt    = 1'b0;
         irq_out_nxt = 1'b0;
      end
      case (state_r)
         ST_IDLE:
         begin
            if (cmd_valid && !ign_in)
            begin
               cmd_nxt     = cmd;
               bidx_nxt    = buf_index;
               irq_req_nxt = irq_sel;
               resp_nxt.ignored        = 1'b0;
               resp_nxt.illegal        = illegal_in;
               resp_nxt.msg_error      = illegal_in;
               resp_nxt.dyn_bus_accept = 1'b0;
               resp_nxt.rx_data        = 1'b0;
               resp_nxt.send_status    = !cmd.broadcast;
               resp_nxt.send_data      = !cmd.broadcast && !illegal_in &&
                                         cmd.tr_bit && has_data(cmd);
               resp_nxt.tx_data        = resp_nxt.send_data ? rd_word : 16'h0000;
               if (!cmd.tr_bit && has_data(cmd))
                  state_nxt = ST_RXDATA;
               else
               begin
                  resp_valid_nxt = 1'b1;
                  state_nxt      = irq_sel ? ST_LOG : ST_IDLE;
               end
            end
            else if (cmd_valid)
            begin
               resp_nxt.ignored = 1'b1;
               resp_valid_nxt   = 1'b0;
            end
         end
         ST_RXDATA:
         begin
            if (data_valid)
            begin
               store_en         = !resp_r.illegal;
               tbl_we           = store_en && mode_data_in_table_opt;
               mem_we           = store_en && !mode_data_in_table_opt;
               resp_nxt.rx_data = 1'b1;
               resp_valid_nxt   = 1'b1;
               state_nxt        = irq_req_r ? ST_LOG : ST_IDLE;
            end
         end
         ST_LOG:
         begin
            log_nxt.info_word = 16'h0000;
            log_nxt.info_word[RMC_IIW_IWA_BIT] = 1'b1;
            log_nxt.addr_word = RMC_DESC_BASE_RST +
                                16'(cmd_index(cmd_r)) * 16'(RMC_DESC_STRIDE);
            log_valid_nxt     = 1'b1;
            state_nxt         = ST_IRQ;
         end
         ST_IRQ:
         begin
            pend_nxt    = 1'b1;
            irq_out_nxt = 1'b1;
            state_nxt   = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r      <= ST_IDLE;
         cmd_r        <= '0;
         bidx_r       <= '0;
         irq_req_r    <= 1'b0;
         resp_valid_r <= 1'b0;
         resp_r       <= '0;
         log_valid_r  <= 1'b0;
         log_r        <= '0;
         pend_r       <= 1'b0;
         irq_out_r    <= 1'b0;
      end
      else
      begin
         state_r      <= state_nxt;
         cmd_r        <= cmd_nxt;
         bidx_r       <= bidx_nxt;
         irq_req_r    <= irq_req_nxt;
         resp_valid_r <= resp_valid_nxt;
         resp_r       <= resp_nxt;
         log_valid_r  <= log_valid_nxt;
         log_r        <= log_nxt;
         pend_r       <= pend_nxt;
         irq_out_r    <= irq_out_nxt;
      end
   end

   // memories carry no reset; host preloads them for predictable answers
   always_ff @(posedge clk_sys)
   begin
      if (mem_we)
         buf_mem[mem_widx] <= store_word;
      else if (mem_wr && !mode_data_in_table_opt)
         buf_mem[mem_addr] <= mem_wdata;
      if (tbl_we)
         table_mem[tbl_widx] <= store_word;
      else if (mem_wr && mode_data_in_table_opt)
         table_mem[mem_addr[4:0]] <= mem_wdata;
   end

   assign resp_valid            = resp_valid_r;
   assign resp                  = resp_r;
   assign log_valid             = log_valid_r;
   assign log_entry             = log_r;
   assign pending_iwa           = pend_r;
   assign message_interrupt_out = irq_out_r;

endmodule // rmc_mode_handler

`default_nettype wire

// >>> bench/rmc_properties.sv
// port checker for the mode command handler
`timescale 1ns/100ps
`default_nettype none
module rmc_properties
(
   input wire logic               clk_sys,
   input wire logic               reset_n,
   input wire logic               undefined_codes_invalid_opt,
   input wire logic               cmd_valid,
   input wire rmc_pkg::rmc_cmd_s  cmd,
   input wire logic               data_valid,
   input wire logic               resp_valid,
   input wire rmc_pkg::rmc_resp_s resp,
   input wire logic               log_valid,
   input wire rmc_pkg::rmc_log_s  log_entry,
   input wire logic               pending_iwa,
   input wire logic               message_interrupt_out
);
   import rmc_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   logic       ign;
   logic [5:0] last_r;
   logic [5:0] last_nxt;
   // ****
   // helpers
   // ****
   // assumes no command is offered while the block is busy
   always_comb
   begin
      ign = cmd_valid && undefined_codes_invalid_opt && (cmd.tr_bit ?
         cmd.mode_code inside {17, 20, 21} : !cmd.mode_code[4] || cmd.mode_code inside {16, 18, 19});
      last_nxt = cmd_valid ? {cmd.tr_bit, cmd.mode_code} : last_r;
   end
   always_ff @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
         last_r <= 6'h00;
      else
         last_r <= last_nxt;
   sequence s_rx_cmd;
      cmd_valid && !cmd.tr_bit && cmd.mode_code[4] && !ign;
   endsequence
   sequence s_irq_up;
      ##1 message_interrupt_out && pending_iwa;
   endsequence
   a_dyn_never: assert property (resp_valid |-> !resp.dyn_bus_accept)
      else $error("dynamic bus acceptance set");
   a_undef_quiet: assert property (ign |=> (!resp_valid && !log_valid) [*3])
      else $error("ignored command answered");
   a_nodata_answer: assert property (cmd_valid && !cmd.mode_code[4] && !ign
      |=> resp_valid && !resp.send_data) else $error("no-data code answer wrong");
   a_tx_word: assert property (cmd_valid && cmd.tr_bit && cmd.mode_code[4] && !cmd.broadcast
      && !ign |=> resp_valid && resp.send_data != resp.illegal) else $error("transmit word wrong");
   a_rx_pair: assert property (s_rx_cmd ##1 data_valid |-> !resp_valid ##1 resp_valid)
      else $error("receive answer not after data");
   a_illegal_err: assert property (resp_valid && resp.illegal |-> resp.msg_error
      && !resp.send_data) else $error("illegal answer wrong");
   a_bcast_quiet: assert property (cmd_valid && cmd.broadcast && !cmd.mode_code[4] && !ign
      |=> resp_valid && !resp.send_status) else $error("broadcast status sent");
   a_log_addr: assert property (log_valid |-> log_entry.info_word[RMC_IIW_IWA_BIT] &&
      log_entry.addr_word == RMC_DESC_BASE_RST + {9'h000, last_r, 1'b0}) else $error("log word wrong");
   a_irq_after_log: assert property (log_valid |-> s_irq_up)
      else $error("interrupt not after log");
   a_irq_cause: assert property ($rose(message_interrupt_out) |-> $past(log_valid))
      else $error("interrupt without log");
endmodule // rmc_properties
bind rmc_mode_handler rmc_properties i_props (.clk_sys, .reset_n, .undefined_codes_invalid_opt,
   .cmd_valid, .cmd, .data_valid, .resp_valid, .resp, .log_valid, .log_entry, .pending_iwa,
   .message_interrupt_out);
`default_nettype wire

// >>> bench/rmc_bc_model.sv
// bus controller model issuing mode commands
`timescale 1ns/100ps
`default_nettype none
module rmc_bc_model
(
   input wire logic          clk_sys,
   output rmc_pkg::rmc_cmd_s cmd,
   output logic              cmd_valid,
   output logic              data_valid,
   output logic [15:0]       data_word,
   output logic [15:0]       desc_ctrl_word,
   output logic [5:0]        buf_index
);
   import rmc_pkg::*;
   initial
   begin
      cmd = '0;
      cmd_valid = 1'b0;
      data_valid = 1'b0;
      data_word = 16'h0000;
      desc_ctrl_word = 16'h0000;
      buf_index = 6'h00;
   end
   // ****
   // one command, then its data word for receive codes 16-31
   // ****
   task automatic send(input rmc_cmd_s c, input logic [15:0] d, input logic [15:0] ctrl);
      @(posedge clk_sys);
      cmd_valid      <= 1'b1;
      cmd            <= c;
      desc_ctrl_word <= ctrl;
      buf_index      <= {1'b0, c.mode_code};
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      cmd       <= ~c;
      if (!c.tr_bit && c.mode_code[4])
      begin
         data_valid <= 1'b1;
         data_word  <= d;
         @(posedge clk_sys);
         data_valid <= 1'b0;
         // released line shows no stale word
         data_word  <= ~d;
      end
   endtask
endmodule // rmc_bc_model
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the mode command handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
   import rmc_pkg::*;
   logic clk_sys, reset_n, undefined_codes_invalid_opt, mode_data_in_table_opt, irq_enable_iwa;
   logic cmd_valid, data_valid, tbl_wr, tbl_bit, pending_clear, mem_wr, resp_valid, log_valid;
   logic pending_iwa, message_interrupt_out;
   logic [15:0] data_word, desc_ctrl_word, mem_wdata, exp_r [2][32];
   logic [5:0]  buf_index, tbl_addr, mem_addr;
   rmc_cmd_s    cmd;
   rmc_resp_s   resp, got;
   rmc_log_s    log_entry, lg;
   int          error_cnt, total_checks, n_resp, n_log;
   rmc_mode_handler #(.BUF_WORDS(64)) i_dut (.clk_sys, .reset_n, .undefined_codes_invalid_opt,
      .mode_data_in_table_opt, .irq_enable_iwa, .cmd_valid, .cmd, .data_valid, .data_word,
      .desc_ctrl_word, .buf_index, .tbl_wr, .tbl_addr, .tbl_bit, .pending_clear, .mem_wr,
      .mem_addr, .mem_wdata, .resp_valid, .resp, .log_valid, .log_entry, .pending_iwa,
      .message_interrupt_out);
   rmc_bc_model i_bc (.clk_sys, .cmd, .cmd_valid, .data_valid, .data_word, .desc_ctrl_word,
      .buf_index);
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      if (resp_valid) begin n_resp++; got = resp; end
      if (log_valid) begin n_log++; lg = log_entry; end
   end
   // ****
   // access tasks
   // ****
   task automatic pulse(input logic t, input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      {tbl_wr, mem_wr} <= {!t, t};
      {tbl_addr, mem_addr, tbl_bit, mem_wdata} <= {a, a, d[0], d};
      @(posedge clk_sys);
      {tbl_wr, mem_wr} <= 2'b00;
   endtask
   task automatic xact(input logic b, tr, input logic [4:0] c, input logic [15:0] d, ctrl,
                       input logic ill);
      logic sd;
      logic op;
      sd = !b && tr && c[4] && !ill;
      op = mode_data_in_table_opt;
      n_resp = 0;
      n_log = 0;
      i_bc.send('{b, tr, c}, d, ctrl);
      repeat (4) @(posedge clk_sys);
      if (undefined_codes_invalid_opt && (tr ? c inside {17, 20, 21} : !c[4] || c inside {16, 18, 19}))
         `CHK("ignored", 0, n_resp)
      else begin
         `CHK("answers", 1, n_resp)
         `CHK("flags", {ill, !b, sd, ill, 1'b0}, {got.illegal, got.send_status, got.send_data, got.msg_error, got.dyn_bus_accept})
         `CHK("rx_data", !tr && c[4], got.rx_data)
         if (sd) `CHK("tx_data", exp_r[op][c], got.tx_data)
         if (!tr && c[4] && !ill) exp_r[op][c] = d;
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      summarize();
   end
   initial
   begin
      {reset_n, undefined_codes_invalid_opt, mode_data_in_table_opt, irq_enable_iwa} = 4'h0;
      {tbl_wr, tbl_bit, pending_clear, mem_wr, tbl_addr, mem_addr, mem_wdata} = '0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      `CHK("reset", 4'h0, {resp_valid, log_valid, pending_iwa, message_interrupt_out})
      for (int o = 0; o < 2; o++)
         for (int c = 16; c < 32; c++) begin
            mode_data_in_table_opt <= o[0];
            exp_r[o][c] = 16'hc000 + 16'(o * 64 + c);
            pulse(1'b1, 6'(c), exp_r[o][c]);
         end
      // pass 0 plain, 1 option drops, 2 all illegal, 3 broadcast into the table store
      for (int p = 0; p < 4; p++) begin
         undefined_codes_invalid_opt <= (p == 1);
         mode_data_in_table_opt <= p[0];
         for (int a = 0; a < 64; a++)
            pulse(1'b0, 6'(a), {15'h0000, p == 2});
         for (int a = 0; a < 64; a++)
            xact(p == 3, a[5], a[4:0], 16'h3000 + 16'(p * 64 + a), 16'h0000, p == 2);
         $display("test %0d done", p);
      end
      undefined_codes_invalid_opt <= 1'b0;
      // third pass: broadcast transmit 17 must not interrupt even when enabled
      for (int e = 0; e < 3; e++) begin
         irq_enable_iwa <= (e != 0);
         xact(e == 2, e != 0, (e != 0) ? 5'd17 : 5'd2, 16'h1234, 16'h8000, 1'b0);
         `CHK("irq", {2{e == 1}}, {pending_iwa, message_interrupt_out})
         if (e == 1) `CHK("log", {16'h8000, RMC_DESC_BASE_RST + 16'h0062}, {lg.info_word & 16'h8000, lg.addr_word})
         @(posedge clk_sys);
         pending_clear <= 1'b1;
         @(posedge clk_sys);
         pending_clear <= 1'b0;
         @(posedge clk_sys);
         `CHK("irq_clr", 2'b00, {pending_iwa, message_interrupt_out})
      end
      $display("test irq done");
      summarize();
   end
endmodule // tb
`default_nettype wire
